//--- tcw_top.sv
// tick counter and watchdog sharing one prescaler
// assumes a core issuing instructions over the register port, synchronous pins
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
module tcw_top
    import tcw_pkg::*;
#(
    parameter int WDT_TICK_CYCLES = (WDT_PERIOD_US * CLK_MHZ) / WDT_BASE_TICKS
)
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // external count pin
    input wire logic count_pin,
    // status outputs
    output logic irq,
    output logic wdt_reset,
    output logic sleeping
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    reg_req_t req;
    logic [7:0] tick_count_reg;
    logic [7:0] ctl_reg;
    logic [7:0] wdc_reg;
    logic [7:0] pre_reg;
    logic [7:0] wdt_reg;
    logic [1:0] sts_reg;
    logic [1:0] mask_reg;
    logic [7:0] rdata_reg;
    logic irq_reg;
    logic wdt_reset_reg;
    logic [1:0] div_reg;
    power_state_t pwr_reg;
    ctl_fields_t ctl;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign ctl = decode_ctl(ctl_reg);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic wr_tick = req.wr && req.addr == ADDR_TICK_COUNT;
    wire logic wr_ctl = req.wr && req.addr == ADDR_COUNTER_CONTROL;
    wire logic wr_wdc = req.wr && req.addr == ADDR_WATCHDOG_CONTROL;
    wire logic wr_sts = req.wr && req.addr == ADDR_IRQ_STATUS;
    wire logic wr_mask = req.wr && req.addr == ADDR_IRQ_MASK;
    wire logic wr_cmd = req.wr && req.addr == ADDR_COMMAND;
    wire logic cmd_clear = wr_cmd && req.wdata[CMD_WDT_CLEAR_BIT];
    wire logic cmd_sleep = wr_cmd && req.wdata[CMD_SLEEP_BIT];
    wire logic cmd_wake = wr_cmd && req.wdata[CMD_WAKE_BIT];
    wire logic in_sleep = (pwr_reg == PWR_SLEEP);
    wire logic wdt_on = wdc_reg[WDC_ENABLE_BIT];

    // ------------------------------------------------------------
    // clock sources
    // ------------------------------------------------------------
    logic pin_edge;
    logic rc_tick;

    tcw_edge_detect u_edge (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .pin(count_pin),
        .falling(ctl.falling_edge),
        .edge_pulse(pin_edge)
    );

    // rc tick keeps running while asleep
    tcw_rc_osc #(.TICK_CYCLES(WDT_TICK_CYCLES)) u_rc (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .tick(rc_tick)
    );

    // instruction clock is clk over two or four
    wire logic [1:0] div_last = ctl.clk_div4 ? 2'h3 : 2'h1;
    wire logic instr_tick = (div_reg == div_last) && !in_sleep;

    // source select for the counter input
    wire logic cnt_in = ctl.external_src ? pin_edge : instr_tick;

    // ------------------------------------------------------------
    // shared prescaler
    // ------------------------------------------------------------
    // one prescaler fed by exactly one timer's input
    wire logic pre_in = ctl.assign_wdt ? rc_tick : cnt_in;
    // ratio field picks the terminal count
    wire logic [7:0] pre_mask = ratio_mask(ctl.ratio, ctl.assign_wdt);
    wire logic pre_done = pre_in && ((pre_reg & pre_mask) == pre_mask);
    // clears that reach the prescaler depend on assignment
    wire logic pre_clear = (wr_tick && !ctl.assign_wdt)
                         || ((cmd_clear || cmd_sleep) && ctl.assign_wdt);

    // assigned timer steps on prescaler period, the other directly
    wire logic cnt_step = ctl.assign_wdt ? cnt_in : pre_done;
    wire logic wdt_step = ctl.assign_wdt ? pre_done : rc_tick;

    // ------------------------------------------------------------
    // watchdog time-out
    // ------------------------------------------------------------
    // clear and sleep restart the watchdog count
    wire logic wdt_restart = cmd_clear || cmd_sleep;
    // 256 rc ticks make the base period
    wire logic wdt_at_top = (wdt_reg == 8'hFF);
    wire logic wdt_expire = wdt_on && wdt_step && wdt_at_top;

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    // overflow as the counter steps past its top count
    wire logic cnt_wrap = cnt_step && (tick_count_reg == 8'hFF);
    wire logic [1:0] events = {wdt_expire, cnt_wrap};
    wire logic [1:0] sts_clear = wr_sts ? req.wdata[1:0] : 2'h0;
    // set wins over a clear in the same cycle, so no event is lost
    wire logic [1:0] sts_next = (sts_reg & ~sts_clear) | events;
    wire logic irq_next = |(sts_next & mask_reg);

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    power_state_t pwr_next;
    logic sleeping_reg;
    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            PWR_RUN: pwr_next = cmd_sleep ? PWR_SLEEP : PWR_RUN;
            PWR_SLEEP: pwr_next = (cmd_wake || wdt_expire) ? PWR_RUN : PWR_SLEEP;
            default: pwr_next = PWR_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (req.addr)
            ADDR_TICK_COUNT: rd_mux = tick_count_reg;
            ADDR_COUNTER_CONTROL: rd_mux = ctl_reg;
            ADDR_WATCHDOG_CONTROL: rd_mux = wdc_reg;
            ADDR_IRQ_STATUS: rd_mux = {6'h00, sts_reg};
            ADDR_IRQ_MASK: rd_mux = {6'h00, mask_reg};
            ADDR_STATE: rd_mux = {6'h00, wdt_reset_reg, in_sleep};
            default: rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // counting state
    // ------------------------------------------------------------
    // reset and time-out clear both counts
    always_ff @(posedge clk) begin
        if (srst || (ce && wdt_expire)) begin
            pre_reg <= 8'h00;
        end else if (ce) begin
            if (pre_clear) begin
                pre_reg <= 8'h00;
            end else if (pre_in) begin
                pre_reg <= pre_done ? 8'h00 : pre_reg + 8'h01;
            end
        end
    end

    // watchdog restarts on reset, time-out, clear or sleep
    always_ff @(posedge clk) begin
        if (srst || (ce && wdt_expire)) begin
            wdt_reg <= 8'h00;
        end else if (ce) begin
            if (wdt_restart) begin
                wdt_reg <= 8'h00;
            end else if (wdt_step) begin
                wdt_reg <= wdt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_reg <= 2'h0;
        end else if (ce) begin
            div_reg <= (div_reg >= div_last) ? 2'h0 : div_reg + 2'h1;
        end
    end

    // counter steps by one and wraps through zero
    always_ff @(posedge clk) begin
        if (srst) begin
            tick_count_reg <= 8'h00;
        end else if (ce) begin
            if (wr_tick) begin
                tick_count_reg <= req.wdata;
            end else if (cnt_step) begin
                tick_count_reg <= tick_count_reg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // control, status and outputs
    // ------------------------------------------------------------
    // counter control, bit 7 reads back as one
    always_ff @(posedge clk) begin
        if (srst) begin
            ctl_reg <= CTL_RESET;
        end else if (ce && wr_ctl) begin
            ctl_reg <= {1'b1, req.wdata[6:0]};
        end
    end

    // enable bit writable at any time
    always_ff @(posedge clk) begin
        if (srst) begin
            wdc_reg <= WDC_RESET;
        end else if (ce && wr_wdc) begin
            wdc_reg <= {req.wdata[WDC_ENABLE_BIT], 7'h00};
        end
    end

    // sticky status, mask and level interrupt
    always_ff @(posedge clk) begin
        if (srst) begin
            sts_reg <= IRQ_RESET;
            mask_reg <= IRQ_RESET;
            irq_reg <= 1'b0;
        end else if (ce) begin
            sts_reg <= sts_next;
            irq_reg <= irq_next;
            if (wr_mask) begin
                mask_reg <= req.wdata[1:0];
            end
        end
    end

    // time-out pulses the device reset and wakes from sleep
    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_reg <= PWR_RUN;
            sleeping_reg <= 1'b0;
            wdt_reset_reg <= 1'b0;
        end else if (ce) begin
            pwr_reg <= pwr_next;
            sleeping_reg <= (pwr_next == PWR_SLEEP);
            wdt_reset_reg <= wdt_expire;
        end
    end

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= 8'h00;
        end else if (ce) begin
            rdata_reg <= req.rd ? rd_mux : 8'h00;
        end
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;
    assign wdt_reset = wdt_reset_reg;
    assign sleeping = sleeping_reg;
endmodule

//--- tcw_pkg.sv
// package for the tick counter / watchdog / prescaler block
// assumes a single 25 MHz clock domain and a plain register port
package tcw_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses on the register port)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TICK_COUNT = 8'h00;
    localparam logic [7:0] ADDR_COUNTER_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_COMMAND = 8'h14;
    localparam logic [7:0] ADDR_STATE = 8'h18;

    // ------------------------------------------------------------
    // counter and watchdog control field positions and reset values
    // ------------------------------------------------------------
    localparam int CTL_RATIO_LSB = 0;
    localparam int CTL_ASSIGN_BIT = 3;
    localparam int CTL_EDGE_BIT = 4;
    localparam int CTL_SOURCE_BIT = 5;
    localparam int CTL_CLKDIV_BIT = 6;
    localparam logic [7:0] CTL_RESET = 8'hBF;
    localparam int WDC_ENABLE_BIT = 7;
    localparam logic [7:0] WDC_RESET = 8'h80;

    // ------------------------------------------------------------
    // command bits and interrupt status bits
    // ------------------------------------------------------------
    localparam int CMD_WDT_CLEAR_BIT = 0;
    localparam int CMD_SLEEP_BIT = 1;
    localparam int CMD_WAKE_BIT = 2;
    localparam int IRQ_OVERFLOW_BIT = 0;
    localparam int IRQ_TIMEOUT_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // ------------------------------------------------------------
    // timing: watchdog base period and rc oscillator
    // ------------------------------------------------------------
    localparam int WDT_PERIOD_US = 18000;
    localparam int WDT_BASE_TICKS = 256;
    localparam int CLK_MHZ = 25;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_SLEEP = 2'b01
    } power_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [2:0] ratio;
        logic assign_wdt;
        logic falling_edge;
        logic external_src;
        logic clk_div4;
    } ctl_fields_t;

    function automatic ctl_fields_t decode_ctl(input logic [7:0] v);
        ctl_fields_t f;
        f.ratio = v[CTL_RATIO_LSB +: 3];
        f.assign_wdt = v[CTL_ASSIGN_BIT];
        f.falling_edge = v[CTL_EDGE_BIT];
        f.external_src = v[CTL_SOURCE_BIT];
        f.clk_div4 = v[CTL_CLKDIV_BIT];
        return f;
    endfunction

    // terminal count of the prescaler: tick counter gets 2^(r+1), watchdog 2^r
    function automatic logic [7:0] ratio_mask(input logic [2:0] r, input logic to_wdt);
        logic [8:0] full;
        full = (9'h002 << r) - 9'h001;
        return to_wdt ? {1'b0, full[7:1]} : full[7:0];
    endfunction

endpackage

//--- tcw_edge_detect.sv
// edge detector for the external count pin
// assumes the pin is already synchronous to clk
`timescale 1ns/1ps
module tcw_edge_detect
    import tcw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // pin and edge choice
    input wire logic pin,
    input wire logic falling,
    // result
    output logic edge_pulse
);
    logic last_reg;
    logic edge_reg;
    wire logic hit = falling ? (last_reg & ~pin) : (~last_reg & pin);

    always_ff @(posedge clk) begin
        if (srst) begin
            last_reg <= 1'b0;
            edge_reg <= 1'b0;
        end else if (ce) begin
            last_reg <= pin;
            edge_reg <= hit;
        end
    end

    assign edge_pulse = edge_reg;
endmodule

//--- tcw_rc_osc.sv
// watchdog rc oscillator model: free running tick divided from clk
// assumes clk keeps running in sleep (stands in for the on-chip rc)
`timescale 1ns/1ps
module tcw_rc_osc
    import tcw_pkg::*;
#(
    parameter int TICK_CYCLES = (WDT_PERIOD_US * CLK_MHZ) / WDT_BASE_TICKS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // tick
    output logic tick
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
    logic [CW-1:0] cnt_reg;
    logic tick_reg;
    wire logic wrap = (cnt_reg == LAST);

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (ce) begin
            cnt_reg <= wrap ? '0 : cnt_reg + CW'(1);
            tick_reg <= wrap;
        end
    end

    assign tick = tick_reg;
endmodule

//--- tcw_props.sv
// checker on the ports of tcw_top
// assumes ce drops only while the port is quiet, and one clock domain
`timescale 1ns/1ps
module tcw_props
    import tcw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // status
    input wire logic irq,
    input wire logic wdt_reset,
    input wire logic sleeping
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire logic cmd_wr = wr && addr == ADDR_COMMAND;
    wire logic wdc_wr = wr && addr == ADDR_WATCHDOG_CONTROL;
    wire logic msk_wr = wr && addr == ADDR_IRQ_MASK;
    // shadows of what software wrote, to compare reads and the irq against
    logic en_q;
    logic [1:0] mask_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            en_q <= 1'b1;
            mask_q <= 2'h0;
        end else if (wdc_wr) begin
            en_q <= wdata[WDC_ENABLE_BIT];
        end else if (msk_wr) begin
            mask_q <= wdata[1:0];
        end
    end
    property p_wdt_pulse;
        wdt_reset |=> !wdt_reset;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("reset pulse too long");
    property p_wake_tmo;
        wdt_reset |-> ##[0:2] !sleeping;
    endproperty
    a_wake_tmo: assert property (p_wake_tmo) else $error("time-out did not wake");
    property p_sleep_enter;
        cmd_wr && wdata[CMD_SLEEP_BIT] |-> ##[1:2] sleeping;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
    property p_clear_quiet;
        cmd_wr && wdata[CMD_WDT_CLEAR_BIT] |=> !wdt_reset [*8];
    endproperty
    a_clear_quiet: assert property (p_clear_quiet) else $error("time-out after clear");
    property p_mask_off;
        msk_wr && wdata == 8'h00 |-> ##[1:2] !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq stayed high");
    property p_masked;
        mask_q == 2'h0 && $past(mask_q) == 2'h0 && $past(mask_q, 2) == 2'h0 |-> !irq;
    endproperty
    a_masked: assert property (p_masked) else $error("irq while masked");
    property p_wdc_read;
        rd && addr == ADDR_WATCHDOG_CONTROL |=> rdata[WDC_ENABLE_BIT] == en_q;
    endproperty
    a_wdc_read: assert property (p_wdc_read) else $error("enable bit read wrong");
    property p_rd_idle;
        !$past(rd) |-> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule

//--- pin_model.sv
// count pin model: a burst of whole pulses, idle low
// assumes start is a one-cycle request from the bench
`timescale 1ns/1ps
module pin_model (
    // clock
    input wire logic clk,
    // request
    input wire logic start,
    input wire logic [7:0] pulses,
    // pin
    output logic count_pin
);
    logic [8:0] left = 9'h000;
    logic pin_reg = 1'b0;
    // one rise and one fall per pulse
    always @(posedge clk) begin
        if (start) begin
            left <= {pulses, 1'b0};
        end else if (left != 9'h000) begin
            pin_reg <= ~pin_reg;
            left <= left - 9'h001;
        end
    end
    assign count_pin = pin_reg;
endmodule

//--- tb_tcw_top.sv
// directed tests of tcw_top over its register port
// assumes pin_model drives the count pin and tcw_props watches the ports
`timescale 1ns/1ps
module tb_tcw_top
    import tcw_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic start = 1'b0;
    logic [7:0] pulses = 8'h00;
    logic [7:0] rdata;
    logic count_pin;
    logic irq;
    logic wdt_reset;
    logic sleeping;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    int resets = 0;
    int n;
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] cfg [4] = '{8'h08, 8'h48, 8'h00, 8'h01};
    int win [4] = '{40, 80, 80, 160};
    logic [7:0] edg [2] = '{8'h38, 8'h28};
    int wper [2] = '{1024, 2048};
    initial forever #20 clk = ~clk;
    // short rc tick keeps a time-out near a thousand cycles
    tcw_top #(.WDT_TICK_CYCLES(4)) dut (.clk(clk), .srst(srst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .count_pin(count_pin), .irq(irq),
        .wdt_reset(wdt_reset), .sleeping(sleeping));
    pin_model pin (.clk(clk), .start(start), .pulses(pulses), .count_pin(count_pin));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
    endtask
    // counts gained over k cycles, read to read
    task automatic span(input int k, output logic [7:0] d);
        logic [7:0] a;
        rreg(ADDR_TICK_COUNT, a);
        idle(k - 2);
        rreg(ADDR_TICK_COUNT, d);
        d = d - a;
    endtask
    task automatic tmo(output int t);
        t = 0;
        while (wdt_reset !== 1'b1 && t < 5000) begin
            @(posedge clk);
            #1 t++;
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wdt_reset === 1'b1) begin
            resets <= resets + 1;
        end
        if (cyc == 60000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        idle(12);
        srst <= 1'b0;
        rreg(ADDR_COUNTER_CONTROL, v);
        check("ctl", v, 8'hBF);
        rreg(ADDR_WATCHDOG_CONTROL, v);
        check("wdc", v, 8'h80);
        rreg(ADDR_IRQ_STATUS, v);
        check("sts", v, 8'h00);
        rreg(8'h1C, v);
        check("gap", v, 8'h00);
        wreg(ADDR_WATCHDOG_CONTROL, 8'h00);
        foreach (cfg[i]) begin
            wreg(ADDR_COUNTER_CONTROL, cfg[i]);
            span(win[i], v);
            check("rate", v, 8'h14);
        end
        foreach (edg[i]) begin
            wreg(ADDR_COUNTER_CONTROL, edg[i]);
            rreg(ADDR_TICK_COUNT, v);
            @(posedge clk);
            start <= 1'b1;
            pulses <= 8'h0A;
            @(posedge clk);
            start <= 1'b0;
            idle(40);
            rreg(ADDR_TICK_COUNT, w);
            check("edges", w - v, 8'h0A);
        end
        wreg(ADDR_COUNTER_CONTROL, 8'h07);
        wreg(ADDR_TICK_COUNT, 8'h05);
        idle(498);
        rreg(ADDR_TICK_COUNT, v);
        check("pclr", v, 8'h05);
        idle(28);
        rreg(ADDR_TICK_COUNT, v);
        check("pstep", v, 8'h06);
        wreg(ADDR_COUNTER_CONTROL, 8'h08);
        wreg(ADDR_TICK_COUNT, 8'hFE);
        idle(10);
        rreg(ADDR_TICK_COUNT, v);
        check("wrap", v & 8'hF8, 8'h00);
        // ce low for 20 edges: only four enabled edges count, two steps
        rreg(ADDR_TICK_COUNT, v);
        @(posedge clk);
        ce <= 1'b0;
        idle(20);
        ce <= 1'b1;
        idle(1);
        rreg(ADDR_TICK_COUNT, w);
        check("hold", w - v, 8'h02);
        rreg(ADDR_IRQ_STATUS, v);
        check("ovf", v, 8'h01);
        check("irq0", {7'h00, irq}, 8'h00);
        wreg(ADDR_IRQ_MASK, 8'h01);
        idle(3);
        check("irq1", {7'h00, irq}, 8'h01);
        wreg(ADDR_IRQ_STATUS, 8'h01);
        idle(3);
        check("irq2", {7'h00, irq}, 8'h00);
        wreg(ADDR_IRQ_MASK, 8'h00);
        // restart first, so enabling cannot meet a count already at the top
        wreg(ADDR_COMMAND, 8'h01);
        wreg(ADDR_WATCHDOG_CONTROL, 8'h80);
        foreach (wper[i]) begin
            wreg(ADDR_COUNTER_CONTROL, i == 0 ? 8'h00 : 8'h09);
            wreg(ADDR_COMMAND, 8'h01);
            tmo(n);
            check("tmo", {7'h00, n > wper[i] - 24 && n < wper[i] + 24}, 8'h01);
        end
        rreg(ADDR_IRQ_STATUS, v);
        check("tsts", v & 8'h02, 8'h02);
        wreg(ADDR_IRQ_STATUS, 8'h03);
        wreg(ADDR_COUNTER_CONTROL, 8'h00);
        n = resets;
        repeat (4) begin
            idle(700);
            wreg(ADDR_COMMAND, 8'h01);
        end
        check("alive", 8'(resets - n), 8'h00);
        wreg(ADDR_COMMAND, 8'h02);
        idle(2);
        check("sleep", {7'h00, sleeping}, 8'h01);
        span(40, v);
        check("frozen", v, 8'h00);
        tmo(n);
        check("stmo", {7'h00, n > 958 && n < 1006}, 8'h01);
        idle(3);
        check("wake", {7'h00, sleeping}, 8'h00);
        wreg(ADDR_WATCHDOG_CONTROL, 8'h00);
        wreg(ADDR_COMMAND, 8'h02);
        n = resets;
        idle(1500);
        check("off", 8'(resets - n), 8'h00);
        wreg(ADDR_COMMAND, 8'h04);
        idle(2);
        check("woke", {7'h00, sleeping}, 8'h00);
        stop_test();
    end
endmodule
bind tcw_top tcw_props chk (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .wdt_reset(wdt_reset), .sleeping(sleeping));
